// ===== design/psr_top.sv
// Pump status relay and lamp decoder
`timescale 1ns/10ps
module psr_top (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start_cmd,
    input  wire logic rotor_turning,
    input  wire logic at_speed,
    input  wire logic error_present,
    output logic      drive_enable,
    output logic      normal_relay,
    output logic      error_relay,
    output logic      run_lamp_green,
    output logic      fault_lamp_red,
    output logic      converter_fault
);
    import psr_pkg::*;

    logic                   rst_m_q;
    logic                   rst_s_q;
    logic [3:0]             in_s;
    logic [3:0]             flags_q;
    logic                   start_f;
    logic                   turn_f;
    logic                   speed_f;
    logic                   err_f;
    logic [FLASH_CNT_W-1:0] flash_cnt_q;
    logic                   flash_q;
    psr_mode_e              mode_d;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // Pin inputs pass two flops each
    psr_sync u_sync_start (
        .clk   (clk),
        .rst_n (rst_s_q),
        .d     (start_cmd),
        .q     (in_s[0])
    );
    psr_sync u_sync_turn (
        .clk   (clk),
        .rst_n (rst_s_q),
        .d     (rotor_turning),
        .q     (in_s[1])
    );
    psr_sync u_sync_speed (
        .clk   (clk),
        .rst_n (rst_s_q),
        .d     (at_speed),
        .q     (in_s[2])
    );
    psr_sync u_sync_err (
        .clk   (clk),
        .rst_n (rst_s_q),
        .d     (error_present),
        .q     (in_s[3])
    );

    // Registered input flags
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= in_s;
        end
    end

    assign start_f = flags_q[0];
    assign turn_f  = flags_q[1];
    assign speed_f = flags_q[2];
    assign err_f   = flags_q[3];

    // Mode decode; at speed without turning is not a table row
    always_comb begin
        if (speed_f && !turn_f) begin
            mode_d = PSR_BAD;
        end else if (err_f) begin
            mode_d = PSR_ERR;
        end else if (start_f && turn_f && speed_f) begin
            mode_d = PSR_RUN;
        end else if (turn_f) begin
            mode_d = PSR_SPIN;
        end else begin
            mode_d = PSR_IDLE;
        end
    end

    // Free running flash timebase for the green lamp
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            flash_cnt_q <= FLASH_CNT_RST;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q == FLASH_CNT_W'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_q <= FLASH_CNT_RST;
            flash_q     <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // Motor drive enable: start without error, off in reset
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            drive_enable <= OUT_RST;
        end else begin
            drive_enable <= start_f && !err_f;
        end
    end

    // Normal operation relay only in the full run row
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            normal_relay <= OUT_RST;
        end else begin
            normal_relay <= (mode_d == PSR_RUN);
        end
    end

    // Error relay and red lamp follow the error flag alone
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            error_relay    <= OUT_RST;
            fault_lamp_red <= OUT_RST;
        end else begin
            error_relay    <= err_f;
            fault_lamp_red <= err_f;
        end
    end

    // Converter fault on an input row that the status table lacks
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            converter_fault <= OUT_RST;
        end else begin
            converter_fault <= (mode_d == PSR_BAD);
        end
    end

    // Green lamp: steady in normal run, flashing while turning otherwise
    always_ff @(posedge clk or negedge rst_s_q) begin
        if (!rst_s_q) begin
            run_lamp_green <= OUT_RST;
        end else begin
            case (mode_d)
                PSR_RUN:  run_lamp_green <= 1'b1;
                PSR_IDLE: run_lamp_green <= 1'b0;
                default:  run_lamp_green <= turn_f && flash_q;
            endcase
        end
    end

    // Relay checks: normal relay only after the run row, never beside error or fault
    AST_NORMAL_RELAY: assert property (@(posedge clk) disable iff (!rst_s_q)
        normal_relay |-> $past(start_f && turn_f && speed_f && !err_f))
        else $error("normal relay without normal operation");
    AST_NORMAL_ON: assert property (@(posedge clk) disable iff (!rst_s_q)
        (start_f && turn_f && speed_f && !err_f) |=> normal_relay)
        else $error("normal relay passive in normal operation");
    AST_NO_RUN_ERR: assert property (@(posedge clk) disable iff (!rst_s_q)
        !(normal_relay && error_relay))
        else $error("normal and error relay both active");
    AST_NO_RUN_FAULT: assert property (@(posedge clk) disable iff (!rst_s_q)
        converter_fault |-> !normal_relay)
        else $error("normal relay during converter fault");

    // Error outputs and motor drive enable
    AST_ERROR_OUTS: assert property (@(posedge clk) disable iff (!rst_s_q)
        ##1 (error_relay == $past(err_f)) && (fault_lamp_red == error_relay))
        else $error("error relay or red lamp wrong");
    AST_DRIVE_EN: assert property (@(posedge clk) disable iff (!rst_s_q)
        err_f |=> !drive_enable)
        else $error("drive enabled during error");
    AST_DRIVE_STOP: assert property (@(posedge clk) disable iff (!rst_s_q)
        !start_f |=> !drive_enable)
        else $error("drive enabled after stop");
    AST_DRIVE_ON: assert property (@(posedge clk) disable iff (!rst_s_q)
        (start_f && !err_f) |=> drive_enable)
        else $error("drive not enabled on start");

    // Green lamp and its flash timebase
    AST_LAMP_OFF: assert property (@(posedge clk) disable iff (!rst_s_q)
        !turn_f |=> !run_lamp_green)
        else $error("green lamp on while rotor still");
    AST_LAMP_STEADY: assert property (@(posedge clk) disable iff (!rst_s_q)
        (mode_d == PSR_RUN)[*3] |=> run_lamp_green)
        else $error("green lamp not steady in normal run");
    AST_LAMP_FLASH: assert property (@(posedge clk) disable iff (!rst_s_q)
        (turn_f && !(start_f && speed_f && !err_f)) |=> (run_lamp_green == $past(flash_q)))
        else $error("green lamp not following the flash phase");
    AST_FLASH_BOUND: assert property (@(posedge clk) disable iff (!rst_s_q)
        flash_cnt_q <= FLASH_CNT_W'(FLASH_HALF_CYC - 1))
        else $error("flash counter beyond its half period");
    AST_FLASH_HOLD: assert property (@(posedge clk) disable iff (!rst_s_q)
        (flash_cnt_q != FLASH_CNT_W'(FLASH_HALF_CYC - 1)) |=> $stable(flash_q))
        else $error("flash phase changed inside a half period");

    // Fault decode, flag register and reset levels
    AST_FAULT_DECODE: assert property (@(posedge clk) disable iff (!rst_s_q)
        converter_fault == $past(speed_f && !turn_f))
        else $error("converter fault decode wrong");
    AST_FLAGS_FOLLOW: assert property (@(posedge clk) disable iff (!rst_s_q)
        flags_q == $past(in_s))
        else $error("input flags not refreshed each cycle");
    AST_RESET_OFF: assert property (@(posedge clk)
        !rst_s_q |-> !(drive_enable || normal_relay || error_relay || run_lamp_green
                       || fault_lamp_red || converter_fault))
        else $error("output active during reset");

    // Main scenarios
    COV_RUN: cover property (@(posedge clk) disable iff (!rst_s_q) normal_relay);
    COV_ERR: cover property (@(posedge clk) disable iff (!rst_s_q) error_relay && drive_enable == 1'b0);
    COV_FLASH: cover property (@(posedge clk) disable iff (!rst_s_q)
        (mode_d == PSR_SPIN) ##1 $rose(run_lamp_green));
    COV_FAULT: cover property (@(posedge clk) disable iff (!rst_s_q) converter_fault);
    COV_RUN_TO_ERR: cover property (@(posedge clk) disable iff (!rst_s_q)
        normal_relay ##1 (error_relay && !normal_relay));
endmodule

// ===== design/psr_pkg.sv
// Constants and types for the pump status relay logic
// Function
// - Normal relay: start, turning, at speed, no error
// - Error relay and red lamp follow error
// - Drive enable: start and no error
// - Green steady normal, flashing when turning otherwise
// - Undefined input combination flagged as converter fault
package psr_pkg;
    // Flash half period: 250 ms at 10 MHz
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned FLASH_HALF_MS   = 250;
    localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int unsigned FLASH_CNT_W     = 22;
    localparam logic [21:0] FLASH_CNT_RST   = 22'h00_0000;
    localparam logic        OUT_RST         = 1'b0;

    // Operating modes decoded from the input flags
    typedef enum logic [4:0] {
        PSR_IDLE  = 5'b0_0001,
        PSR_SPIN  = 5'b0_0010,
        PSR_RUN   = 5'b0_0100,
        PSR_ERR   = 5'b0_1000,
        PSR_BAD   = 5'b1_0000
    } psr_mode_e;
endpackage

// ===== design/psr_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module psr_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // First flop feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ===== test/psr_ctrl_model.sv
// Controller and sensor model that drives the pump status flags
`timescale 1ns/10ps
module psr_ctrl_model (
    input  wire logic       clk,
    input  wire logic [3:0] cmd,
    output logic            start_cmd,
    output logic            rotor_turning,
    output logic            at_speed,
    output logic            error_present
);
    // Flags are levels, changed just after the clock edge and then held
    always_ff @(posedge clk) begin
        {start_cmd, rotor_turning, at_speed, error_present} <= cmd;
    end
endmodule

// ===== test/psr_top_bench.sv
// Self-checking bench for the pump status relay decoder
`timescale 1ns/10ps
module psr_top_bench;
    logic       clk;
    logic       rst_n;
    logic [3:0] cmd;
    logic       start_cmd;
    logic       rotor_turning;
    logic       at_speed;
    logic       error_present;
    logic       drive_enable;
    logic       normal_relay;
    logic       error_relay;
    logic       run_lamp_green;
    logic       fault_lamp_red;
    logic       converter_fault;
    logic       s;
    logic       t;
    logic       a;
    logic       e;
    int         err_count;
    int         n_checks;

    // Far side that owns the four input flags
    psr_ctrl_model ctrl (.clk(clk), .cmd(cmd), .start_cmd(start_cmd),
        .rotor_turning(rotor_turning), .at_speed(at_speed), .error_present(error_present));

    psr_top uut (.clk(clk), .rst_n(rst_n), .start_cmd(start_cmd),
        .rotor_turning(rotor_turning), .at_speed(at_speed), .error_present(error_present),
        .drive_enable(drive_enable), .normal_relay(normal_relay), .error_relay(error_relay),
        .run_lamp_green(run_lamp_green), .fault_lamp_red(fault_lamp_red),
        .converter_fault(converter_fault));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare one output against its expected level
    task automatic chk(input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: output %b, expected %b", $time, seen, exp);
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Walk every flag combination, the error one right after normal running
    initial begin
        err_count = 0;
        n_checks  = 0;
        rst_n     = 1'b1;
        cmd       = 4'h0;
        // Fall once every process waits, so all flops see the reset edge
        #10;
        rst_n     = 1'b0;
        repeat (15) @(posedge clk);
        #1;
        chk(drive_enable | normal_relay | error_relay, 1'b0);
        chk(run_lamp_green | fault_lamp_red | converter_fault, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            cmd <= i[3:0];
            {s, t, a, e} = i[3:0];
            repeat (8) @(posedge clk);
            #1;
            chk(drive_enable, s & ~e);
            chk(normal_relay, s & t & a & ~e);
            chk(error_relay, e);
            chk(fault_lamp_red, e);
            chk(converter_fault, a & ~t);
            // Flash phase is far longer than a step, so only steady levels are compared
            if (!t) begin
                chk(run_lamp_green, 1'b0);
            end else if (s & a & ~e) begin
                chk(run_lamp_green, 1'b1);
            end
        end
        // Reset in the middle of normal running, then a clean restart
        @(posedge clk);
        cmd <= 4'hE;
        repeat (8) @(posedge clk);
        #1;
        chk(normal_relay & drive_enable & run_lamp_green, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk(drive_enable | normal_relay | run_lamp_green, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(normal_relay, 1'b1);
        chk(run_lamp_green, 1'b1);
        chk(drive_enable, 1'b1);
        end_of_test();
    end

    // Watchdog well beyond the expected 180 cycles
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        end_of_test();
    end
endmodule
